// *** hw/otcm_top.sv ***
// Oscillator trim registers and clock multiplier control
// ---------------------------------------------------------------
// How it works
// - Coarse trim code sets oscillator period monotonic
// - Coarse trim top bit reads zero
// - Coarse trim resets to calibrated 24 MHz value
// - Fine trim resets to calibrated value
// - Fine trim upper two bits read zero
// - Output is four times input, then scaled
// - Input: external, internal halved, external halved
// - Ready set only after output stabilises
// - Slow input: four fast pulses, then idle
// - Control register layout, resets to zero
// - Ready one means loop locked
// ---------------------------------------------------------------
//
// The address-and-strobe port was left to the implementer.
`include "otcm_map.svh"
module otcm_top #(
  parameter logic [6:0] COARSE_CAL = 7'h40, // Per-part value, arbitrary
  parameter logic [5:0] FINE_CAL = 6'h20, // Per-part value, arbitrary
  parameter int LOCK_CYCLES = `OTCM_LOCK_CYCLES
) (
  input wire logic clock, // 250 MHz block clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clock_enable, // Freezes all state but the reset release when low
  input wire logic [7:0] address, // Register address
  input wire logic [7:0] write_data, // Register write data
  input wire logic write_strobe, // One-cycle write
  input wire logic read_strobe, // One-cycle read
  output logic [7:0] read_data, // Read data, cycle after strobe
  input wire logic ext_osc, // External oscillator
  input wire logic int_osc, // Internal oscillator
  output logic [6:0] coarse_trim, // To oscillator period control
  output logic [5:0] fine_trim, // To oscillator fine control
  output logic mult_clock, // Multiplied clock
  output logic multiplier_ready, // Loop locked
  output logic irq // Level interrupt
);
  import otcm_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic multiplier_enable;
  logic multiplier_initialize;
  logic [2:0] multiplier_scale;
  otcm_sel_t multiplier_input_select;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic trim_loaded;
  otcm_state_t state;
  logic [31:0] lock_count;
  logic locked;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire hit_ctrl = (address == `OTCM_ADDR_MULT_CTRL);
  wire hit_fine = (address == `OTCM_ADDR_FINE_TRIM);
  wire hit_coarse = (address == `OTCM_ADDR_COARSE_TRIM);
  wire hit_status = (address == `OTCM_ADDR_IRQ_STATUS);
  wire hit_mask = (address == `OTCM_ADDR_IRQ_MASK);
  wire wr_ctrl = write_strobe && hit_ctrl;
  wire wr_fine = write_strobe && hit_fine;
  wire wr_coarse = write_strobe && hit_coarse;
  wire wr_status = write_strobe && hit_status;
  wire wr_mask = write_strobe && hit_mask;
  wire [7:0] ctrl_view = {multiplier_enable, multiplier_initialize,
                          locked, multiplier_scale,
                          multiplier_input_select};
  wire [7:0] fine_view = {2'b00, fine_trim} & `OTCM_FINE_MASK;
  wire [7:0] coarse_view = {1'b0, coarse_trim} & `OTCM_COARSE_MASK;
  wire [7:0] status_view = {6'h00, irq_status};
  wire [7:0] mask_view = {6'h00, irq_mask};
  wire [7:0] next_read_data =
    hit_ctrl ? ctrl_view :
    hit_fine ? fine_view :
    hit_coarse ? coarse_view :
    hit_status ? status_view :
    hit_mask ? mask_view : 8'h00;

  // ---------------------------------------------------------------
  // Control and mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= 8'h00;
      multiplier_enable <= 1'b0;
      multiplier_initialize <= 1'b0;
      multiplier_scale <= 3'h0;
      multiplier_input_select <= OTCM_SEL_EXT;
      irq_mask <= 2'b00;
    end else if (clock_enable) begin
      // Falls back to zero so a stale value never lingers on the bus
      read_data <= read_strobe ? next_read_data : 8'h00;
      if (wr_ctrl) begin
        multiplier_enable <= write_data[`OTCM_BIT_ENABLE];
        multiplier_initialize <= write_data[`OTCM_BIT_INIT];
        multiplier_scale <=
          write_data[`OTCM_SCALE_HI:`OTCM_SCALE_LO];
        multiplier_input_select <=
          otcm_sel_t'(write_data[`OTCM_SEL_HI:`OTCM_SEL_LO]);
      end
      // Only the two defined status bits can be unmasked
      if (wr_mask) begin
        irq_mask <= write_data[1:0] & 2'(`OTCM_IRQ_MASK_BITS);
      end
    end
  end

  // ---------------------------------------------------------------
  // Trim registers
  // ---------------------------------------------------------------
  // Calibration loads one cycle after reset release, not as async value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trim_loaded <= 1'b0;
      coarse_trim <= 7'h00;
      fine_trim <= 6'h00;
    end else if (clock_enable) begin
      if (!trim_loaded) begin
        trim_loaded <= 1'b1;
        coarse_trim <= COARSE_CAL;
        fine_trim <= FINE_CAL;
      end else begin
        if (wr_coarse) begin
          coarse_trim <= write_data[6:0];
        end
        if (wr_fine) begin
          fine_trim <= write_data[5:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Input source
  // ---------------------------------------------------------------
  logic ext_level;
  logic ext_rise;
  logic int_level;
  logic int_rise;
  logic half_ext;
  logic half_int;
  // Oscillators are foreign to the block clock: three flops each
  otcm_edge_sync ext_sync (
    .clock(clock),
    .rst_n(rst_n),
    .enable(clock_enable),
    .async_in(ext_osc),
    .level(ext_level),
    .rise(ext_rise)
  );
  otcm_edge_sync int_sync (
    .clock(clock),
    .rst_n(rst_n),
    .enable(clock_enable),
    .async_in(int_osc),
    .level(int_level),
    .rise(int_rise)
  );
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_ext <= 1'b0;
      half_int <= 1'b0;
    end else if (clock_enable) begin
      if (ext_rise) begin
        half_ext <= !half_ext;
      end
      if (int_rise) begin
        half_int <= !half_int;
      end
    end
  end
  // Halved sources count every second rise
  // The reserved select code gives no reference edges at all
  wire ref_rise =
    (multiplier_input_select == OTCM_SEL_EXT) ? ext_rise :
    (multiplier_input_select == OTCM_SEL_INT_HALF) ?
      (int_rise && half_int) :
    (multiplier_input_select == OTCM_SEL_EXT_HALF) ?
      (ext_rise && half_ext) : 1'b0;

  // ---------------------------------------------------------------
  // Lock sequencing
  // ---------------------------------------------------------------
  logic slow;
  logic tick;
  wire run = multiplier_enable && (state == OTCM_ST_LOCKED ||
                                   state == OTCM_ST_LOCKING);
  // Settling time counts block clocks, whatever the reference rate
  wire lock_done = (lock_count >= 32'(LOCK_CYCLES));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= OTCM_ST_OFF;
      lock_count <= 32'h0;
      locked <= 1'b0;
    end else if (clock_enable) begin
      case (state)
        OTCM_ST_OFF: begin
          locked <= 1'b0;
          lock_count <= 32'h0;
          if (multiplier_enable) begin
            state <= OTCM_ST_ARMED;
          end
        end
        OTCM_ST_ARMED: begin
          if (!multiplier_enable) begin
            state <= OTCM_ST_OFF;
          end else if (multiplier_initialize) begin
            state <= OTCM_ST_LOCKING;
          end
        end
        OTCM_ST_LOCKING: begin
          if (!multiplier_enable) begin
            state <= OTCM_ST_OFF;
          end else if (lock_done) begin
            state <= OTCM_ST_LOCKED;
            locked <= 1'b1;
          end else if (ref_rise) begin
            lock_count <= lock_count + 32'h1;
          end else begin
            lock_count <= lock_count + 32'h1;
          end
        end
        OTCM_ST_LOCKED: begin
          // Clearing initialize drops lock, so a restart settles again
          if (!multiplier_enable || !multiplier_initialize) begin
            state <= OTCM_ST_OFF;
            locked <= 1'b0;
          end
        end
        default: begin
          state <= OTCM_ST_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Multiplied pulse train
  // ---------------------------------------------------------------
  otcm_pulse_gen pulse_gen (
    .clock(clock),
    .rst_n(rst_n),
    .enable(clock_enable),
    .run(run),
    .ref_rise(ref_rise),
    .scale(multiplier_scale),
    .tick(tick),
    .slow(slow)
  );

  // ---------------------------------------------------------------
  // Output clock, ready and interrupt
  // ---------------------------------------------------------------
  // Status bit 0: lock gained; bit 1: slow input seen while running
  wire ev_lock = (state == OTCM_ST_LOCKING) && lock_done;
  wire ev_slow = run && slow;
  wire [1:0] events = {ev_slow, ev_lock};
  wire [1:0] clear = wr_status ? write_data[1:0] : 2'b00;
  // Set wins: an event in the clearing cycle stays visible
  wire [1:0] next_status = (irq_status & ~clear) | events;
  wire next_irq = |(next_status & irq_mask);
  // One block-clock pulse per multiplied period gives four pulses
  // per reference period before scaling
  wire next_mult_clock = tick && locked;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'b00;
      mult_clock <= 1'b0;
      multiplier_ready <= 1'b0;
      irq <= 1'b0;
    end else if (clock_enable) begin
      irq_status <= next_status;
      mult_clock <= next_mult_clock;
      multiplier_ready <= locked;
      irq <= next_irq;
    end
  end
endmodule

// *** hw/otcm_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef OTCM_MAP_SVH
`define OTCM_MAP_SVH
`define OTCM_ADDR_MULT_CTRL 8'h97
`define OTCM_ADDR_FINE_TRIM 8'h9E
`define OTCM_ADDR_COARSE_TRIM 8'hA2
`define OTCM_ADDR_IRQ_STATUS 8'hB0
`define OTCM_ADDR_IRQ_MASK 8'hB1
`define OTCM_ADDR_OSC_SELECT 8'hB2
`define OTCM_BIT_ENABLE 7
`define OTCM_BIT_INIT 6
`define OTCM_BIT_READY 5
`define OTCM_SCALE_HI 4
`define OTCM_SCALE_LO 2
`define OTCM_SEL_HI 1
`define OTCM_SEL_LO 0
`define OTCM_CTRL_RESET 8'h00
`define OTCM_COARSE_MASK 8'h7F
`define OTCM_FINE_MASK 8'h3F
`define OTCM_IRQ_MASK_BITS 8'h03
`define OTCM_LOCK_NS 20000
`define OTCM_CLOCK_MHZ 250
`define OTCM_LOCK_CYCLES ((`OTCM_LOCK_NS * `OTCM_CLOCK_MHZ) / 1000)
`define OTCM_FAST_HALF 1
`define OTCM_SLOW_LIMIT 32
`endif

// *** hw/otcm_pkg.sv ***
// Types shared by the oscillator trim and clock multiplier block
package otcm_pkg;
  typedef enum logic [1:0] {
    OTCM_SEL_EXT,
    OTCM_SEL_INT_HALF,
    OTCM_SEL_EXT_HALF,
    OTCM_SEL_RSVD
  } otcm_sel_t;
  typedef enum {
    OTCM_ST_OFF,
    OTCM_ST_ARMED,
    OTCM_ST_LOCKING,
    OTCM_ST_LOCKED
  } otcm_state_t;
endpackage

// *** hw/otcm_edge_sync.sv ***
// Three-flop synchroniser with rising-edge pulse for a foreign clock input
module otcm_edge_sync (
  input wire logic clock, // Block clock
  input wire logic rst_n, // Synchronous-released reset
  input wire logic enable, // Clock enable
  input wire logic async_in, // Foreign level
  output logic level, // Settled level
  output logic rise // One-cycle pulse on settled rise
);
  logic stage1;
  logic stage2;
  logic stage3;
  wire agree = (stage2 == stage3);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else if (enable) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (agree) begin
        level <= stage3;
      end
    end
  end
  assign rise = enable && agree && stage3 && !level;
endmodule

// *** hw/otcm_pulse_gen.sv ***
// Burst generator: four output edges per reference rise, then scaled
`include "otcm_map.svh"
module otcm_pulse_gen #(
  parameter int SLOW_LIMIT = `OTCM_SLOW_LIMIT
) (
  input wire logic clock, // Block clock
  input wire logic rst_n, // Reset
  input wire logic enable, // Clock enable
  input wire logic run, // Multiplier running
  input wire logic ref_rise, // Reference rising edge pulse
  input wire logic [2:0] scale, // Output scaling code
  output logic tick, // One pulse per multiplied period
  output logic slow // Reference below minimum rate
);
  logic [2:0] left;
  logic [2:0] gap;
  logic [2:0] skip;
  logic [7:0] since;
  // Codes 000-010 keep factor one; 011..111 emit 2 of every N ticks
  wire [2:0] modulus = (scale < 3'h3) ? 3'h1 : scale;
  wire raw = (left != 3'h0) && (gap == 3'h0);
  wire keep = (modulus == 3'h1) || (skip < 3'h2);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left <= 3'h0;
      gap <= 3'h0;
      skip <= 3'h0;
      since <= 8'h00;
      tick <= 1'b0;
      slow <= 1'b0;
    end else if (enable) begin
      tick <= run && raw && keep;
      if (!run) begin
        left <= 3'h0;
        skip <= 3'h0;
      end else if (ref_rise) begin
        left <= 3'h4;
        gap <= 3'h0;
      end else if (raw) begin
        left <= left - 3'h1;
        gap <= 3'(`OTCM_FAST_HALF);
        skip <= (skip + 3'h1 >= modulus) ? 3'h0 : skip + 3'h1;
      end else if (gap != 3'h0) begin
        gap <= gap - 3'h1;
      end
      if (ref_rise) begin
        slow <= (since >= 8'(SLOW_LIMIT));
        since <= 8'h00;
      end else if (since != 8'hFF) begin
        since <= since + 8'h01;
      end
    end
  end
endmodule

// *** sim/otcm_top_properties.sv ***
// Port-level checks for the trim registers and the clock multiplier
module otcm_top_properties #(
  parameter int LOCK_CYCLES = 5000
) (
  input wire logic clock, // Block clock
  input wire logic reset_n, // Active-low reset
  input wire logic clock_enable, // Clock enable
  input wire logic [7:0] address, // Register address
  input wire logic [7:0] write_data, // Write data
  input wire logic write_strobe, // Write strobe
  input wire logic read_strobe, // Read strobe
  input wire logic [7:0] read_data, // Read data
  input wire logic ext_osc, // External oscillator
  input wire logic int_osc, // Internal oscillator
  input wire logic [6:0] coarse_trim, // Coarse trim
  input wire logic [5:0] fine_trim, // Fine trim
  input wire logic mult_clock, // Multiplied clock
  input wire logic multiplier_ready, // Lock flag
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic rd, wr, ctl_wr, init_was;
  logic [15:0] wait_cnt;
  assign rd = read_strobe && clock_enable;
  assign wr = write_strobe && clock_enable;
  assign ctl_wr = wr && address == 8'h97;
  // Last written initialize bit, so a repeated start is not mistaken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      init_was <= 1'b0;
    end else if (ctl_wr) begin
      init_was <= write_data[6];
    end
  end
  // Cycles since a fresh initialize request, saturating
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 16'h0000;
    end else if (ctl_wr && write_data[7:6] == 2'b11 && !init_was) begin
      wait_cnt <= 16'h0000;
    end else if (wait_cnt != 16'hFFFF) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  property p_read_idle;
    !rd && clock_enable |=> read_data == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside a read");
  property p_coarse_read;
    rd && address == 8'hA2 |=> read_data == {1'b0, $past(coarse_trim)};
  endproperty
  a_coarse_read: assert property (p_coarse_read)
    else $error("coarse trim read mismatch");
  property p_fine_read;
    rd && address == 8'h9E |=> read_data == {2'b00, $past(fine_trim)};
  endproperty
  a_fine_read: assert property (p_fine_read)
    else $error("fine trim read mismatch");
  property p_coarse_wr;
    wr && address == 8'hA2
      |=> {1'b0, coarse_trim} == ($past(write_data) & 8'h7F);
  endproperty
  a_coarse_wr: assert property (p_coarse_wr)
    else $error("coarse trim not written");
  property p_fine_wr;
    wr && address == 8'h9E
      |=> {2'b00, fine_trim} == ($past(write_data) & 8'h3F);
  endproperty
  a_fine_wr: assert property (p_fine_wr)
    else $error("fine trim not written");
  // ---------------------------------------------------------------
  // Multiplier
  // ---------------------------------------------------------------
  property p_ready_bit;
    rd && address == 8'h97 |=> read_data[5] == multiplier_ready;
  endproperty
  a_ready_bit: assert property (p_ready_bit)
    else $error("ready bit and ready port differ");
  property p_ready_drop;
    ctl_wr && write_data[7:6] != 2'b11 |-> ##[1:4] !multiplier_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready held after multiplier stop");
  property p_ready_wait;
    ctl_wr && write_data[7:6] == 2'b11 && !init_was && !multiplier_ready
      |=> !multiplier_ready [*8];
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready set before settling time");
  property p_lock_time;
    $rose(multiplier_ready) |-> wait_cnt >= 16'(LOCK_CYCLES);
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("ready set before the settling count");
  property p_clk_quiet;
    !multiplier_ready [*4] |-> $stable(mult_clock);
  endproperty
  a_clk_quiet: assert property (p_clk_quiet)
    else $error("multiplied clock moves while unlocked");
  c_lock: cover property ($rose(multiplier_ready));
  c_irq: cover property ($rose(irq));
  c_ctl_read: cover property (rd && address == 8'h97);
endmodule
bind otcm_top otcm_top_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
  .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .ext_osc(ext_osc), .int_osc(int_osc),
  .coarse_trim(coarse_trim), .fine_trim(fine_trim),
  .mult_clock(mult_clock), .multiplier_ready(multiplier_ready), .irq(irq)
);

// *** sim/tb_otcm_top.sv ***
// Self-checking bench for the trim registers and clock multiplier
module tb_otcm_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Stimulus and tasks
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic ext_osc = 1'b0;
  logic int_osc = 1'b0;
  logic [7:0] read_data, d, cfg;
  logic [6:0] coarse_trim;
  logic [5:0] fine_trim;
  logic mult_clock, multiplier_ready, irq, mc;
  int mismatches = 0;
  int n_tests = 0;
  int tries, toggles, per, exp_t, nd;
  // Rows: address, write data, expected read back
  logic [23:0] rows [9] = '{24'hA2FF7F, 24'hA20000, 24'h9EFF3F,
    24'h9E0000, 24'h971F1F, 24'h97FFDF, 24'h970000, 24'hB1FF03, 24'h00FF00};
  always #2 clock = ~clock;
  // Internal 10 cycles, external 80 cycles: external is below min rate
  always #20 int_osc = ~int_osc; // Halved x4 x2/4 gives 25 MHz
  always #160 ext_osc = ~ext_osc;
  otcm_top #(.LOCK_CYCLES(20)) dut_u (.clock(clock), .reset_n(reset_n),
    .clock_enable(1'b1), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .ext_osc(ext_osc), .int_osc(int_osc),
    .coarse_trim(coarse_trim), .fine_trim(fine_trim),
    .mult_clock(mult_clock), .multiplier_ready(multiplier_ready), .irq(irq));
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clock);
    address <= a;
    write_data <= v;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 v = read_data;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1 check("coarse port", {1'b0, coarse_trim}, 8'h40);
    rd(8'hA2, d);
    check("coarse reset", d, 8'h40);
    rd(8'h9E, d);
    check("fine reset", d, 8'h20);
    rd(8'h97, d);
    check("control reset", d, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], d);
      check("register row", d, rows[i][7:0]);
    end
    $display("register table test done");
    for (int s = 0; s < 4; s++) begin
      cfg = (s == 3) ? 8'h01 : 8'(s + ((s + 3) << 2));
      wr(8'h97, 8'h00);
      wr(8'hB0, 8'h03);
      wr(8'h97, cfg & 8'h03);
      wr(8'h97, cfg);
      wr(8'h97, cfg | 8'h80);
      repeat (1300) @(posedge clock);
      wr(8'h97, cfg | 8'hC0);
      rd(8'h97, d);
      check("ready early", {7'h00, d[5]}, 8'h00);
      tries = 0;
      while (d[5] !== 1'b1 && tries < 100) begin
        rd(8'h97, d);
        tries++;
      end
      if (tries == 100) begin
        mismatches++;
        wrap_up();
      end
      check("lock delay", {7'h00, tries >= 9}, 8'h01);
      check("control locked", d, cfg | 8'hE0);
      repeat (2) @(posedge clock);
      #1 check("irq on lock", {7'h00, irq}, 8'h01);
      toggles = 0;
      mc = mult_clock;
      repeat (400) begin
        @(posedge clock);
        #1 if (mult_clock === 1'b1 && mc === 1'b0) toggles++;
        mc = mult_clock;
      end
      // Rises: four per reference period, two kept of every nd
      per = (s % 2 == 1) ? 20 : (s == 0 ? 80 : 160);
      nd = (s == 3) ? 2 : s + 3;
      exp_t = 3200 / (per * nd);
      check("tick count",
        {7'h00, toggles >= exp_t - 3 && toggles <= exp_t + 3},
        8'h01);
      rd(8'hB0, d);
      check("status", d, {6'h00, s % 2 == 0, 1'b1});
      wr(8'hB1, 8'h00);
      @(posedge clock);
      #1 check("irq masked", {7'h00, irq}, 8'h00);
      wr(8'hB1, 8'h03);
      if (s % 2 == 1) begin
        wr(8'hB0, 8'h03);
        #1 check("irq cleared", {7'h00, irq}, 8'h00);
      end
      wr(8'h97, 8'h00);
      repeat (4) @(posedge clock);
      #1 check("ready drop", {7'h00, multiplier_ready}, 8'h00);
      $display("lock test %0d done", s);
    end
    wrap_up();
  end
endmodule
